// ### fsr_status.v
// two-byte status register of a serial flash with its own serial command decode
// assumes spi mode 0 or 3 pins, engine signals on mclk_in, rst_in acting as power-up
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"

module fsr_status (
  // clock and reset
  input wire mclk_in,
  input wire rst_in,
  // serial pins
  input wire cs_n_in,
  input wire sclk_in,
  input wire si_in,
  input wire wp_n_in,
  output wire so_out,
  output wire so_oe_out,
  // state from the program, erase and protection engines
  input wire busy_in,
  input wire prog_susp_in,
  input wire erase_susp_in,
  input wire any_prot_in,
  input wire all_prot_in,
  input wire op_end_in,
  input wire op_fail_in,
  input wire op_abort_in,
  input wire wtype_opcode_in,
  input wire wtype_end_in,
  input wire hold_abort_in,
  input wire freeze_done_in,
  // permissions and requests to the engines
  output wire write_allowed_out,
  output wire protect_allowed_out,
  output wire lockdown_allowed_out,
  output reg soft_reset_out,
  output reg global_req_out,
  output reg [3:0] global_bits_out,
  // status bits
  output wire [7:0] status_one_out,
  output wire [7:0] status_two_out
);

  // pin synchronisers
  wire [3:0] pins_s;
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire wp_n_s;

  fsr_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in({cs_n_in, sclk_in, si_in, wp_n_in}),
    .rst_val_in(`FSR_RST_PINS),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  // edge detection on synchronised levels
  reg cs_n_prev_q;
  reg sclk_prev_q;
  wire frame_end;
  wire sclk_rise;
  wire sclk_fall;

  assign frame_end = cs_n_s & ~cs_n_prev_q;
  assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_q;

  // serial input state
  reg [2:0] bit_idx_q;
  reg [1:0] byte_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] opcode_q;
  reg [7:0] data_q;
  wire [7:0] shift_next;
  wire aligned;
  wire opcode_full;
  wire data_full;

  assign shift_next = {shift_q[6:0], si_s};
  assign aligned = (bit_idx_q == 3'h0);
  assign opcode_full = (byte_cnt_q != 2'h0);
  assign data_full = (byte_cnt_q[1] == 1'b1);

  // status bits
  reg protect_lock_q;
  reg program_error_flag_q;
  reg write_enable_latch_q;
  reg reset_enable_q;
  reg lockdown_enable_q;
  reg frozen_q;
  reg [1:0] software_protect_summary;

  always @* begin
    if (all_prot_in) begin
      software_protect_summary = `FSR_SWP_ALL;
    end else if (any_prot_in) begin
      software_protect_summary = `FSR_SWP_SOME;
    end else begin
      software_protect_summary = `FSR_SWP_NONE;
    end
  end

  // byte one: lock, unused, error, wp level, summary, latch, busy
  assign status_one_out = {protect_lock_q, 1'b0, program_error_flag_q, wp_n_s,
    software_protect_summary, write_enable_latch_q, busy_in};
  // byte two: unused top bits read zero
  assign status_two_out = {3'h0, reset_enable_q, lockdown_enable_q,
    prog_susp_in, erase_susp_in, busy_in};

  // permissions seen by the engines
  assign write_allowed_out = write_enable_latch_q;
  assign protect_allowed_out = write_enable_latch_q & ~protect_lock_q;
  assign lockdown_allowed_out = write_enable_latch_q & lockdown_enable_q;

  // frame end decisions; commands act only on whole bytes, but a status write clears the latch at any frame end after its opcode
  wire end_ok;
  wire do_wren;
  wire do_wrdi;
  wire do_wr_one;
  wire do_wr_two;
  wire do_reset;
  wire wr_cmd_seen;
  wire lock_refused;

  assign end_ok = frame_end & aligned;
  assign do_wren = end_ok & (opcode_q == `FSR_OP_WRITE_ENABLE) & (byte_cnt_q == 2'h1);
  assign do_wrdi = end_ok & (opcode_q == `FSR_OP_WRITE_DISABLE) & (byte_cnt_q == 2'h1);
  assign do_wr_one = end_ok & data_full & write_enable_latch_q &
    (opcode_q == `FSR_OP_WRITE_ONE);
  assign do_wr_two = end_ok & data_full & write_enable_latch_q &
    (opcode_q == `FSR_OP_WRITE_TWO);
  assign do_reset = end_ok & data_full & reset_enable_q &
    (opcode_q == `FSR_OP_SOFT_RESET) & (data_q == `FSR_RESET_CONFIRM);
  // a status write whose opcode arrived, whether it completes or aborts
  assign wr_cmd_seen = frame_end & opcode_full &
    ((opcode_q == `FSR_OP_WRITE_ONE) | (opcode_q == `FSR_OP_WRITE_TWO));
  // clearing the lock while wp is asserted drops the whole write
  assign lock_refused = ~wp_n_s & protect_lock_q & ~data_q[`FSR_B1_LOCK];

  // serial receive
  always @(posedge mclk_in) begin
    if (rst_in) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      bit_idx_q <= 3'h0;
      byte_cnt_q <= 2'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
      if (cs_n_s) begin
        bit_idx_q <= 3'h0;
        if (!frame_end) begin
          byte_cnt_q <= 2'h0;
          opcode_q <= 8'h00;
        end
      end else if (sclk_rise) begin
        shift_q <= shift_next;
        bit_idx_q <= bit_idx_q + 3'h1;
        if (bit_idx_q == 3'h7) begin
          // bytes past the data byte are ignored
          if (byte_cnt_q == 2'h0) begin
            opcode_q <= shift_next;
          end else if (byte_cnt_q == 2'h1) begin
            data_q <= shift_next;
          end
          if (byte_cnt_q != 2'h3) begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
          end
        end
      end
    end
  end

  // status bit updates
  always @(posedge mclk_in) begin
    if (rst_in) begin
      protect_lock_q <= `FSR_RST_LOCK;
      program_error_flag_q <= `FSR_RST_ERROR;
      write_enable_latch_q <= `FSR_RST_WEL;
      reset_enable_q <= `FSR_RST_RESET_ENABLE;
      lockdown_enable_q <= `FSR_RST_SLE;
      frozen_q <= 1'b0;
      soft_reset_out <= 1'b0;
      global_req_out <= 1'b0;
      global_bits_out <= 4'h0;
    end else begin
      soft_reset_out <= do_reset;
      global_req_out <= 1'b0;

      // only the lock bit of byte one is writable
      if (do_wr_one && !lock_refused) begin
        protect_lock_q <= data_q[`FSR_B1_LOCK];
        // global protect judged against the lock held before the write
        if (!protect_lock_q) begin
          global_req_out <= 1'b1;
          global_bits_out <= data_q[`FSR_GLOBAL_HI:`FSR_GLOBAL_LO];
        end
      end

      // reset_enable changes here and nowhere else; lockdown_enable also clears on freeze just below
      if (do_wr_two) begin
        reset_enable_q <= data_q[`FSR_B2_RESET_ENABLE];
        if (!frozen_q) begin
          lockdown_enable_q <= data_q[`FSR_B2_SLE];
        end
      end
      if (freeze_done_in || frozen_q) begin
        frozen_q <= 1'b1;
        lockdown_enable_q <= 1'b0;
      end

      // error flag rewritten at each end; an abort leaves it clear
      if (op_end_in) begin
        program_error_flag_q <= op_fail_in & ~op_abort_in;
      end

      // latch: enable wins over a clear in the same cycle
      if (do_wren) begin
        write_enable_latch_q <= 1'b1;
      end else if (do_wrdi || wr_cmd_seen || wtype_end_in || hold_abort_in ||
          wtype_opcode_in || do_reset) begin
        write_enable_latch_q <= 1'b0;
      end
    end
  end

  // status output stream; the host keeps clocking to poll busy
  reg rd_active_q;
  reg byte_sel_q;
  reg [2:0] out_idx_q;
  reg [7:0] out_shift_q;
  reg so_q;
  wire [7:0] fresh_byte;

  assign fresh_byte = byte_sel_q ? status_two_out : status_one_out;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      rd_active_q <= 1'b0;
      byte_sel_q <= 1'b0;
      out_idx_q <= 3'h0;
      out_shift_q <= 8'h00;
      so_q <= 1'b0;
    end else if (cs_n_s) begin
      rd_active_q <= 1'b0;
      byte_sel_q <= 1'b0;
      out_idx_q <= 3'h0;
    end else begin
      // the stream opens on the rising edge that completes the opcode
      if (sclk_rise && (bit_idx_q == 3'h7) && (byte_cnt_q == 2'h0) &&
          (shift_next == `FSR_OP_READ_STATUS)) begin
        rd_active_q <= 1'b1;
      end
      // new bit on each falling edge; byte freshly captured at its start
      if (sclk_fall && rd_active_q) begin
        out_idx_q <= out_idx_q + 3'h1;
        if (out_idx_q == 3'h0) begin
          so_q <= fresh_byte[7];
          out_shift_q <= {fresh_byte[6:0], 1'b0};
        end else begin
          so_q <= out_shift_q[7];
          out_shift_q <= {out_shift_q[6:0], 1'b0};
        end
        if (out_idx_q == 3'h7) begin
          byte_sel_q <= ~byte_sel_q;
        end
      end
    end
  end

  // rule for the far side: polling until busy falls is the host's job
  assign so_out = so_q;
  assign so_oe_out = rd_active_q & ~cs_n_s;

endmodule // fsr_status

`default_nettype wire

// ### fsr_defines.vh
// constants of the flash status register block: opcodes, bit positions, reset values
// assumes inclusion by bare name from the design files
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// serial opcodes and confirmation byte
`define FSR_OP_READ_STATUS 8'h05
`define FSR_OP_WRITE_ONE 8'h01
`define FSR_OP_WRITE_TWO 8'h31
`define FSR_OP_WRITE_ENABLE 8'h06
`define FSR_OP_WRITE_DISABLE 8'h04
`define FSR_OP_SOFT_RESET 8'hF0
`define FSR_RESET_CONFIRM 8'hD0

// status byte one fields
`define FSR_B1_LOCK 7
`define FSR_B1_ERROR 5
`define FSR_B1_WP 4
`define FSR_B1_SWP_HI 3
`define FSR_B1_SWP_LO 2
`define FSR_B1_WEL 1
`define FSR_B1_BUSY 0

// status byte two fields
`define FSR_B2_RESET_ENABLE 4
`define FSR_B2_SLE 3
`define FSR_B2_PS 2
`define FSR_B2_ES 1
`define FSR_B2_BUSY 0

// global protect field of the byte one write data
`define FSR_GLOBAL_HI 5
`define FSR_GLOBAL_LO 2

// protection summary codes
`define FSR_SWP_NONE 2'h0
`define FSR_SWP_SOME 2'h1
`define FSR_SWP_ALL 2'h3

// reset values
`define FSR_RST_LOCK 1'b0
`define FSR_RST_ERROR 1'b0
`define FSR_RST_WEL 1'b0
`define FSR_RST_RESET_ENABLE 1'b0
`define FSR_RST_SLE 1'b0
// synchroniser reset levels {cs_n, sclk, si, wp_n}: deselected, wp released
`define FSR_RST_PINS 4'hD

`endif

// ### fsr_sync.v
// two flip-flop synchroniser for a group of independent pin levels
// assumes each bit is a level held far longer than one clock period
`timescale 1ns/1ps
`default_nettype none

module fsr_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire mclk_in,
  input wire rst_in,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  input wire [WIDTH-1:0] rst_val_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // reset value comes from a constant at the instance
  always @(posedge mclk_in) begin
    if (rst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // fsr_sync

`default_nettype wire

// ### fsr_host_model.sv
// host controller model driving the serial pins, mode 0, msb first
// assumes the device samples si on rising sclk and shifts so on falling sclk
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
  // serial pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end
  // sends nb bits of d; rd keeps the last 16 bits seen on so
  task automatic frame(input logic [23:0] d, input int nb, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n_out = 1'b0;
    #100;
    for (int i = 0; i < nb; i++) begin
      si_out = d[23-i];
      #62.5 sclk_out = 1'b1;
      rd = {rd[14:0], so_oe_in ? so_in : 1'bx};
      #62.5 sclk_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    // a released line must not keep its last level
    si_out = ~si_out;
    #100;
  endtask
  task automatic poll(output logic [15:0] rd, output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      frame(24'h050000, 24, rd);
      ok = (rd[8] === 1'b0);
    end
  endtask
endmodule // fsr_host_model
`default_nettype wire

// ### fsr_status_monitor.sv
// port assertions for the flash status register block
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fsr_status_monitor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // pins and engine inputs
  input wire logic cs_n_in,
  input wire logic busy_in,
  input wire logic prog_susp_in,
  input wire logic erase_susp_in,
  input wire logic any_prot_in,
  input wire logic all_prot_in,
  input wire logic op_end_in,
  input wire logic op_fail_in,
  input wire logic op_abort_in,
  input wire logic wtype_opcode_in,
  input wire logic wtype_end_in,
  input wire logic hold_abort_in,
  input wire logic freeze_done_in,
  // block outputs
  input wire logic write_allowed_out,
  input wire logic protect_allowed_out,
  input wire logic lockdown_allowed_out,
  input wire logic soft_reset_out,
  input wire logic so_oe_out,
  input wire logic [7:0] status_one_out,
  input wire logic [7:0] status_two_out
);
  logic frozen_q = 1'b0;
  wire [7:0] s1 = status_one_out;
  wire [7:0] s2 = status_two_out;
  // freeze has no undo short of power-up
  always @(posedge mclk_in) frozen_q <= !rst_in && (frozen_q || freeze_done_in);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_busy_both: assert property (s1[0] == busy_in && s2[0] == busy_in)
    else $error("busy bits differ from engine");
  a_suspend_flags: assert property ($stable({prog_susp_in, erase_susp_in})
    |-> s2[2:1] == {prog_susp_in, erase_susp_in}) else $error("suspend flags wrong");
  a_reserved_zero: assert property (s2[7:5] == 3'h0 && !s1[6])
    else $error("reserved bit set");
  a_summary_code: assert property ($stable({any_prot_in, all_prot_in})
    |-> s1[3:2] == (all_prot_in ? 2'h3 : {1'b0, any_prot_in})) else $error("summary wrong");
  a_error_set: assert property (op_end_in && op_fail_in && !op_abort_in
    |-> ##[1:2] s1[5]) else $error("error flag not set");
  a_error_abort: assert property (op_end_in && op_abort_in |-> ##[1:2] !s1[5])
    else $error("error flag set on abort");
  a_allow_bits: assert property (write_allowed_out == s1[1]
    && protect_allowed_out == (s1[1] && !s1[7]) && lockdown_allowed_out == (s1[1] && s2[3]))
    else $error("permission outputs wrong");
  a_latch_clear: assert property (wtype_end_in || hold_abort_in || wtype_opcode_in
    |-> ##[1:2] !s1[1]) else $error("latch not cleared");
  a_freeze_perm: assert property (frozen_q |=> !s2[3])
    else $error("lockdown enable after freeze");
  a_reset_keeps: assert property (soft_reset_out
    |-> s2[4] ##1 $stable({s1[7], s2[4:3]})) else $error("soft reset misbehaved");
  a_lock_wp: assert property ($fell(s1[7]) |-> s1[4])
    else $error("lock cleared with pin asserted");
  a_oe_idle: assert property (cs_n_in [*5] |-> !so_oe_out)
    else $error("so driven while deselected");
  c_error_set: cover property (op_end_in && op_fail_in && !op_abort_in);
  c_soft_reset: cover property (soft_reset_out);
  c_read_start: cover property ($rose(so_oe_out));
endmodule // fsr_status_monitor
bind fsr_status fsr_status_monitor u_fsr_status_monitor (
  .mclk_in, .rst_in, .cs_n_in, .busy_in, .prog_susp_in, .erase_susp_in, .any_prot_in,
  .all_prot_in, .op_end_in, .op_fail_in, .op_abort_in, .wtype_opcode_in, .wtype_end_in,
  .hold_abort_in, .freeze_done_in, .write_allowed_out, .protect_allowed_out,
  .lockdown_allowed_out, .soft_reset_out, .so_oe_out, .status_one_out, .status_two_out
);
`default_nettype wire

// ### fsr_status_tb_top.sv
// self-checking bench for the flash status register block
// assumes fsr_status, the host model and the bound monitor are compiled
`timescale 1ns/1ps
`default_nettype none
module fsr_status_tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  // {wp_n, all, any, erase susp, prog susp, busy}
  logic [5:0] lv = 6'h30;
  logic [6:0] ev = 7'h00;
  wire cs_n_in, sclk_in, si_in, so_out, so_oe_out, soft_reset_out, global_req_out;
  wire write_allowed_out, protect_allowed_out, lockdown_allowed_out;
  wire [3:0] global_bits_out;
  wire [7:0] status_one_out, status_two_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_rst = 0;
  int n_greq = 0;
  logic [15:0] rd;
  bit ok;
  fsr_status u_fsr_status (
    .mclk_in, .rst_in, .cs_n_in, .sclk_in, .si_in, .wp_n_in(lv[5]), .so_out, .so_oe_out,
    .busy_in(lv[0]), .prog_susp_in(lv[1]), .erase_susp_in(lv[2]), .any_prot_in(lv[3]),
    .all_prot_in(lv[4]), .op_end_in(ev[0]), .op_fail_in(ev[1]), .op_abort_in(ev[2]),
    .wtype_opcode_in(ev[3]), .wtype_end_in(ev[4]), .hold_abort_in(ev[5]),
    .freeze_done_in(ev[6]), .write_allowed_out, .protect_allowed_out, .lockdown_allowed_out,
    .soft_reset_out, .global_req_out, .global_bits_out, .status_one_out, .status_two_out
  );
  fsr_host_model u_fsr_host_model (
    .cs_n_out(cs_n_in), .sclk_out(sclk_in), .si_out(si_in), .so_in(so_out), .so_oe_in(so_oe_out)
  );
  initial forever #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (soft_reset_out === 1'b1) n_rst++;
    if (global_req_out === 1'b1) n_greq++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input logic [15:0] e);
    chk({status_one_out, status_two_out}, e);
  endtask
  task automatic tx(input logic [23:0] d, input int nb);
    u_fsr_host_model.frame(d, nb, rd);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk_in) ev <= m;
    @(posedge mclk_in) ev <= 7'h00;
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic lvl(input logic [5:0] v);
    @(posedge mclk_in) lv <= v;
    repeat (4) @(posedge mclk_in);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_defaults;
    st(16'h1C00);
    tx(24'h050000, 24);
    chk(rd, 16'h1C00);
    tx(24'hF0D000, 16);
    chk(16'(n_rst), 16'h0000);
  endtask
  task t_byte2;
    tx(24'h060000, 8);
    chk(16'(write_allowed_out), 16'h0001);
    tx(24'h31FF00, 16);
    st(16'h1C18);
    chk(16'(lockdown_allowed_out), 16'h0000);
    tx(24'h060000, 8);
    chk(16'(lockdown_allowed_out), 16'h0001);
    tx(24'h310000, 5);
    chk(16'(status_one_out), 16'h001E);
    pulse(7'h08);
    chk(16'(status_one_out), 16'h001C);
  endtask
  task t_lock;
    lvl(6'h10);
    st(16'h0C18);
    tx(24'h060000, 8);
    tx(24'h01BC00, 16);
    st(16'h8C18);
    chk(16'(n_greq), 16'h0001);
    chk(16'(global_bits_out), 16'h000F);
    tx(24'h060000, 8);
    chk(16'(protect_allowed_out), 16'h0000);
    tx(24'h010000, 16);
    st(16'h8C18);
    tx(24'h060000, 8);
    tx(24'hF0D000, 16);
    chk(16'(n_rst), 16'h0001);
    st(16'h8C18);
    lvl(6'h30);
    tx(24'h060000, 8);
    tx(24'h013C00, 16);
    st(16'h1C18);
    chk(16'(n_greq), 16'h0001);
  endtask
  task t_engine;
    pulse(7'h03);
    chk(16'(status_one_out), 16'h003C);
    pulse(7'h07);
    chk(16'(status_one_out), 16'h001C);
    pulse(7'h03);
    pulse(7'h01);
    chk(16'(status_one_out), 16'h001C);
    tx(24'h060000, 8);
    pulse(7'h20);
    chk(16'(write_allowed_out), 16'h0000);
    tx(24'h060000, 8);
    pulse(7'h10);
    chk(16'(write_allowed_out), 16'h0000);
    tx(24'h060000, 8);
    tx(24'h040000, 8);
    chk(16'(write_allowed_out), 16'h0000);
    tx(24'h060000, 8);
    tx(24'h010000, 8);
    chk(16'(status_one_out), 16'h001C);
    tx(24'h311000, 16);
    chk(16'(status_two_out), 16'h0018);
    pulse(7'h40);
    tx(24'h060000, 8);
    tx(24'h311800, 16);
    st(16'h1C10);
    lvl(6'h28);
    chk(16'(status_one_out), 16'h0014);
    lvl(6'h27);
    tx(24'h050000, 24);
    chk(rd, 16'h1117);
    fork
      begin
        repeat (300) @(posedge mclk_in);
        lv <= 6'h26;
      end
    join_none
    u_fsr_host_model.poll(rd, ok);
    chk(16'(ok), 16'h0001);
    if (!ok) give_verdict();
    else chk(rd, 16'h1016);
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    t_defaults();
    t_byte2();
    t_lock();
    t_engine();
    give_verdict();
  end
endmodule // fsr_status_tb_top
`default_nettype wire
